// File: nvc_pkg.sv
// package for the byte-wide non-volatile array access controller
// assumes one system clock and a synchronous active-low reset
package nvc_pkg;
  // register locations (control register sits in bank 1)
  localparam logic [7:0] NVC_CTRL_OFFSET  = 8'h40;
  localparam logic [1:0] NVC_CTRL_BANK    = 2'h1;
  localparam logic [1:0] NVC_DATA_BANK    = 2'h0;
  localparam logic [7:0] NVC_ADDR_OFFSET  = 8'h01;
  localparam logic [7:0] NVC_DATA_OFFSET  = 8'h02;
  // control field positions
  localparam int NVC_WRITE_ENABLE_BIT = 3;
  localparam int NVC_WR_BIT   = 2;
  localparam int NVC_READ_ENABLE_BIT = 1;
  localparam int NVC_RD_BIT   = 0;
  // reset values
  localparam logic [3:0] NVC_CTRL_RESET = 4'h0;
  localparam logic [1:0] NVC_BANK_RESET = 2'h0;
  localparam logic [7:0] NVC_ADDR_RESET = 8'h00;
  localparam logic [7:0] NVC_DATA_RESET = 8'h00;
  // timing: program cycle length and read latency
  localparam int NVC_CLK_MHZ        = 25;
  localparam int NVC_WRITE_TIME_US  = 4000;
  localparam int NVC_WRITE_CYCLES   = NVC_WRITE_TIME_US * NVC_CLK_MHZ;
  localparam int NVC_READ_CYCLES    = 2;

  // one register access from the core
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [1:0] bank;
    logic [7:0] addr;
    logic [7:0] wdata;
  } nvc_bus_type;
endpackage

// File: nvc_ctrl.sv
// byte access controller for the internal non-volatile data array
// assumes single-cycle register strobes from the core on clk_in
//
// Functional notes
// [RL1] array is 256 or 128 bytes from address zero, not memory mapped
// [RL2] each access moves one byte via address, data and control registers
// [RL3] software reaches control register through pointer 40H and bank 01H
// [RL4] small variant keeps address bits 6..0 only, bit 7 reads zero
// [RL5] control bits: write enable 3, write start 2, read enable 1, read start 0
// [RL6] write enable low refuses all programming
// [RL7] read enable low refuses all reads
// [RL8] write start launches program cycle, hardware clears it at end
// [RL9] write start ignored unless write enable already set
// [RL10] read start launches read cycle, hardware clears it at end
// [RL11] read start ignored unless read enable already set
// [RL12] software never sets both starts or all four bits together
// [RL13] data register holds read byte until next read or write
// [RL14] software loads address and data, then enable, then start
// [RL15] software masks global interrupts around write start
// [RL16] program duration set by an internal timer, seen only via flags
// [RL17] write enable cleared at power-on
// [RL18] bank select resets to zero at power-on
// [RL19] program end sets completion flag and shared request flag
// [RL20] vector request needs global, completion, shared enables, stack not full
// [RL21] servicing clears shared flag only; software clears completion flag
// [RL22] start requests ignored while a program cycle runs
`timescale 1ns/1ps
module nvc_ctrl #(
  parameter int DEPTH         = 256,
  parameter int WRITE_CYCLES  = nvc_pkg::NVC_WRITE_CYCLES
) (
  // clock and reset
  input  wire logic                 clk_in,
  input  wire logic                 rst_n_in,
  // core register port
  input  wire nvc_pkg::nvc_bus_type bus_in,
  input  wire logic                 bank_wr_in,
  input  wire logic [1:0]           bank_wdata_in,
  output logic [7:0]                rdata_out,
  output logic [1:0]                bank_select_out,
  // interrupt side
  input  wire logic                 global_irq_enable_in,
  input  wire logic                 nv_done_irq_enable_in,
  input  wire logic                 mf_irq_enable_in,
  input  wire logic                 stack_full_in,
  input  wire logic                 irq_service_in,
  input  wire logic                 done_flag_clr_in,
  output logic                      nv_done_irq_flag_out,
  output logic                      mf_irq_flag_out,
  output logic                      irq_vector_req_out
);
  // address width and mask follow the array depth [RL4]
  localparam int AW = (DEPTH > 128) ? 8 : 7;
  localparam logic [7:0] AMASK = (DEPTH > 128) ? 8'hff : 8'h7f;
  localparam logic [23:0] WR_LAST = 24'(WRITE_CYCLES - 1);
  localparam logic [23:0] RD_LAST = 24'(nvc_pkg::NVC_READ_CYCLES - 1);

  // timing seen from the core, in clk_in cycles:
  //   a register write lands on the edge that samples bus_in.wr
  //   read data appears on rdata_out one cycle after the address
  //   a start bit launches its cycle on the edge after it sets
  //   read start clears NVC_READ_CYCLES + 1 cycles after it sets
  //   write start clears WRITE_CYCLES + 1 cycles after it sets
  //   the counter stands in for the array's free-running program timer;
  //   an asynchronous timer would need its done pulse synchronised first

  typedef enum logic [1:0] {NVC_IDLE, NVC_READ, NVC_PROG} nvc_state_type;

  // storage: array plus the two bank 0 registers
  logic [7:0]    mem_q [DEPTH];            // not in cpu address space [RL1]
  logic [7:0]    cell_address_q;
  logic [7:0]    cell_data_q;

  // control register bits and bank select
  logic          write_enable_q;
  logic          write_start_q;
  logic          read_enable_q;
  logic          read_start_q;
  logic [1:0]    bank_q;

  // cycle sequencer
  nvc_state_type state_q;
  logic [23:0]   count_q;
  logic          prog_end;
  logic          read_end;

  // interrupt side
  logic          done_q;
  logic          mf_q;
  logic          vec_q;

  // register decode and write strobes
  logic          ctrl_sel;
  logic          addr_sel;
  logic          data_sel;
  logic          ctrl_wr;
  logic          addr_wr;
  logic          data_wr;
  logic          busy;
  logic [7:0]    wd;
  logic [7:0]    rdata_d;

  // one register hit: offset and bank must both match
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off,
                               input logic [1:0] b, input logic [1:0] want);
    hit = (a == off) && (b == want);
  endfunction

  // control register image; the upper nibble is not implemented
  function automatic logic [7:0] ctrl_view(input logic we, input logic ws,
                                           input logic re, input logic rs);
    ctrl_view = {4'h0, we, ws, re, rs};
  endfunction

  // decode: control register only in bank 1 at offset 40h, so a
  // bank select left at zero keeps stray writes away from it [RL3]
  assign wd       = bus_in.wdata;
  assign ctrl_sel = hit(bus_in.addr, nvc_pkg::NVC_CTRL_OFFSET, bank_q, nvc_pkg::NVC_CTRL_BANK);
  assign addr_sel = hit(bus_in.addr, nvc_pkg::NVC_ADDR_OFFSET, bank_q, nvc_pkg::NVC_DATA_BANK);
  assign data_sel = hit(bus_in.addr, nvc_pkg::NVC_DATA_OFFSET, bank_q, nvc_pkg::NVC_DATA_BANK);

  // write strobes; busy covers a pending start as well as a running cycle
  assign ctrl_wr  = bus_in.wr && ctrl_sel;
  assign addr_wr  = bus_in.wr && addr_sel;
  assign data_wr  = bus_in.wr && data_sel;
  assign busy     = state_q != NVC_IDLE || write_start_q || read_start_q; // [RL22]
  assign prog_end = state_q == NVC_PROG && count_q == WR_LAST;
  assign read_end = state_q == NVC_READ && count_q == RD_LAST;

  // bank select, zero after reset keeps control register hidden
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      bank_q <= nvc_pkg::NVC_BANK_RESET; // [RL18]
    else if (bank_wr_in)
      bank_q <= bank_wdata_in;
  end

  // address register; top bit dropped on the small array so it
  // reads back as zero there
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      cell_address_q <= nvc_pkg::NVC_ADDR_RESET;
    else if (addr_wr)
      cell_address_q <= wd & AMASK; // [RL4]
  end

  // write enable: freely writable, cleared at power-on so nothing can be
  // programmed until software asks for it
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      write_enable_q <= nvc_pkg::NVC_CTRL_RESET[nvc_pkg::NVC_WRITE_ENABLE_BIT]; // [RL17] [RL5]
    else if (ctrl_wr)
      write_enable_q <= wd[nvc_pkg::NVC_WRITE_ENABLE_BIT];
  end

  // read enable: freely writable
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      read_enable_q <= nvc_pkg::NVC_CTRL_RESET[nvc_pkg::NVC_READ_ENABLE_BIT];
    else if (ctrl_wr)
      read_enable_q <= wd[nvc_pkg::NVC_READ_ENABLE_BIT];
  end

  // write start: needs write enable from an earlier write; a busy array
  // ignores it, and a start whose enable dropped before launch lapses
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      write_start_q <= nvc_pkg::NVC_CTRL_RESET[nvc_pkg::NVC_WR_BIT];
    else if (prog_end)
      write_start_q <= 1'b0; // [RL8]
    else if (write_start_q && state_q == NVC_IDLE && !write_enable_q)
      write_start_q <= 1'b0; // [RL6]
    else if (ctrl_wr && !busy)
      write_start_q <= wd[nvc_pkg::NVC_WR_BIT] && write_enable_q; // [RL9] [RL6] [RL22]
  end

  // read start: same gating as write start, so it cannot stick high
  // when its enable is withdrawn before the sequencer picks it up
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      read_start_q <= nvc_pkg::NVC_CTRL_RESET[nvc_pkg::NVC_RD_BIT];
    else if (read_end)
      read_start_q <= 1'b0; // [RL10]
    else if (read_start_q && state_q == NVC_IDLE && !read_enable_q)
      read_start_q <= 1'b0; // [RL7]
    else if (ctrl_wr && !busy)
      read_start_q <= wd[nvc_pkg::NVC_RD_BIT] && read_enable_q; // [RL11] [RL7] [RL22]
  end

  // cycle sequencer; the program timer stands in for the array's own timer,
  // a pending write is served before a pending read
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      state_q <= NVC_IDLE;
      count_q <= 24'h000000;
    end
    else
    begin
      case (state_q)
        NVC_IDLE:
        begin
          count_q <= 24'h000000;
          if (write_start_q && write_enable_q)
            state_q <= NVC_PROG;
          else if (read_start_q && read_enable_q)
            state_q <= NVC_READ;
        end
        NVC_READ:
        begin
          count_q <= count_q + 24'h000001;
          if (read_end)
            state_q <= NVC_IDLE;
        end
        NVC_PROG:
        begin
          count_q <= count_q + 24'h000001; // [RL16]
          if (prog_end)
            state_q <= NVC_IDLE;
        end
        default:
          state_q <= NVC_IDLE;
      endcase
    end
  end

  // array write at the end of the program cycle, one byte [RL2];
  // no reset on the array, its contents survive a warm reset
  always_ff @(posedge clk_in)
  begin
    if (prog_end)
      mem_q[cell_address_q[AW-1:0]] <= cell_data_q;
  end

  // data register: loaded by software or by a finished read; software
  // writes are dropped while a program cycle is pending or running [RL13]
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      cell_data_q <= nvc_pkg::NVC_DATA_RESET;
    else if (read_end)
      cell_data_q <= mem_q[cell_address_q[AW-1:0]];
    else if (data_wr && !write_start_q)
      cell_data_q <= wd; // [RL22]
  end

  // completion flag: only software clears it, and a set wins over a
  // clear in the same cycle so no completion is ever lost
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      done_q <= 1'b0;
    else
      done_q <= prog_end | (done_q & ~done_flag_clr_in); // [RL19] [RL21]
  end

  // shared request flag: set beside the completion flag, cleared by service
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      mf_q <= 1'b0;
    else
      mf_q <= prog_end | (mf_q & ~irq_service_in); // [RL19] [RL21]
  end

  // vector request: all three enables and room on the stack; dropped
  // while the request is serviced so one completion vectors only once
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      vec_q <= 1'b0;
    else
      vec_q <= (prog_end | mf_q) & global_irq_enable_in & nv_done_irq_enable_in
               & mf_irq_enable_in & ~stack_full_in & ~irq_service_in; // [RL20]
  end

  // read mux; reserved nibble and unmapped offsets give zero
  always_comb
  begin
    rdata_d = 8'h00;
    if (ctrl_sel)
      rdata_d = ctrl_view(write_enable_q, write_start_q, read_enable_q, read_start_q); // [RL5]
    else if (addr_sel)
      rdata_d = cell_address_q; // [RL4]
    else if (data_sel)
      rdata_d = cell_data_q; // [RL13]
  end

  // registered read data keeps the port free of decode glitches
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      rdata_out <= 8'h00;
    else
      rdata_out <= rdata_d;
  end

  // remaining outputs are plain copies of their flip-flops
  assign bank_select_out      = bank_q;
  assign nv_done_irq_flag_out = done_q;
  assign mf_irq_flag_out      = mf_q;
  assign irq_vector_req_out   = vec_q;
endmodule

// File: nvc_ctrl_checker.sv
// assertions on the ports of the non-volatile byte access controller
// assumes one clock domain and the bind at the foot of this file
`timescale 1ns/1ps
module nvc_ctrl_checker (
  // clock and reset
  input wire logic                 clk_in,
  input wire logic                 rst_n_in,
  // register port
  input wire nvc_pkg::nvc_bus_type bus_in,
  input wire logic                 bank_wr_in,
  input wire logic [1:0]           bank_wdata_in,
  input wire logic [7:0]           rdata_out,
  input wire logic [1:0]           bank_select_out,
  // interrupt side
  input wire logic                 global_irq_enable_in,
  input wire logic                 nv_done_irq_enable_in,
  input wire logic                 mf_irq_enable_in,
  input wire logic                 stack_full_in,
  input wire logic                 irq_service_in,
  input wire logic                 done_flag_clr_in,
  input wire logic                 nv_done_irq_flag_out,
  input wire logic                 mf_irq_flag_out,
  input wire logic                 irq_vector_req_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // released reset still shows the power-on values
  property p_reset_out;
    $rose(rst_n_in) |-> bank_select_out == 2'h0 && !nv_done_irq_flag_out && !mf_irq_flag_out;
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("outputs not clear after reset");
  property p_bank_load;
    bank_wr_in |=> bank_select_out == $past(bank_wdata_in);
  endproperty
  a_bank_load: assert property (p_bank_load) else $error("bank select not loaded");
  // the upper nibble of the control register never reads back set
  property p_ctrl_hi;
    bus_in.addr == nvc_pkg::NVC_CTRL_OFFSET && bank_select_out == nvc_pkg::NVC_CTRL_BANK
      |=> rdata_out[7:4] == 4'h0;
  endproperty
  a_ctrl_hi: assert property (p_ctrl_hi) else $error("control upper bits set");
  property p_vec_cause;
    irq_vector_req_out |-> $past(global_irq_enable_in && nv_done_irq_enable_in
      && mf_irq_enable_in && !stack_full_in);
  endproperty
  a_vec_cause: assert property (p_vec_cause) else $error("vector without enables");
  property p_flag_pair;
    $rose(nv_done_irq_flag_out) |-> mf_irq_flag_out;
  endproperty
  a_flag_pair: assert property (p_flag_pair) else $error("shared flag missing");
  property p_svc_clr;
    irq_service_in |=> !mf_irq_flag_out;
  endproperty
  a_svc_clr: assert property (p_svc_clr) else $error("shared flag not cleared");
  property p_done_clr;
    done_flag_clr_in |=> !nv_done_irq_flag_out;
  endproperty
  a_done_clr: assert property (p_done_clr) else $error("completion flag not cleared");
  // both flags are sticky, so servicing alone must not drop the completion flag
  property p_mf_hold;
    mf_irq_flag_out && !irq_service_in |=> mf_irq_flag_out;
  endproperty
  a_mf_hold: assert property (p_mf_hold) else $error("shared flag dropped");
  property p_done_hold;
    nv_done_irq_flag_out && !done_flag_clr_in |=> nv_done_irq_flag_out;
  endproperty
  a_done_hold: assert property (p_done_hold) else $error("completion flag dropped");
endmodule
bind nvc_ctrl nvc_ctrl_checker chk_u (.*);

// File: eeprom_byte_access_controller_test.sv
// register-level bench for the non-volatile byte access controller
// assumes a program cycle shortened to eight clocks
`timescale 1ns/1ps
module eeprom_byte_access_controller_test;
  localparam logic [7:0] CT = nvc_pkg::NVC_CTRL_OFFSET;
  localparam logic [7:0] AD = nvc_pkg::NVC_ADDR_OFFSET;
  localparam logic [7:0] DT = nvc_pkg::NVC_DATA_OFFSET;
  logic                 clk_in = 1'h0;
  logic                 rst_n_in = 1'h0;
  nvc_pkg::nvc_bus_type bus = 20'h0;
  logic                 bwr = 1'h0;
  logic [1:0]           bwd = 2'h0;
  logic [3:0]           ien = 4'h0;
  logic                 svc = 1'h0;
  logic                 dclr = 1'h0;
  logic [7:0]           rdata;
  logic [1:0]           bank;
  logic                 done_f;
  logic                 mf_f;
  logic                 vec;
  int                   fail_count = 0;
  int                   checks_done = 0;
  nvc_ctrl #(.DEPTH(256), .WRITE_CYCLES(8)) dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .bus_in(bus), .bank_wr_in(bwr), .bank_wdata_in(bwd), .rdata_out(rdata),
    .bank_select_out(bank), .global_irq_enable_in(ien[3]), .nv_done_irq_enable_in(ien[2]),
    .mf_irq_enable_in(ien[1]), .stack_full_in(ien[0]), .irq_service_in(svc),
    .done_flag_clr_in(dclr), .nv_done_irq_flag_out(done_f), .mf_irq_flag_out(mf_f),
    .irq_vector_req_out(vec));
  // 40 ns clock
  initial
  begin
    forever #20 clk_in = ~clk_in;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // bank load, then one write strobe
  task automatic wr(input logic [1:0] b, input logic [7:0] a, input logic [7:0] d);
    bwr <= 1'h1;
    bwd <= b;
    tick(1);
    bwr <= 1'h0;
    bus.wr <= 1'h1;
    bus.addr <= a;
    bus.wdata <= d;
    tick(1);
    bus.wr <= 1'h0;
  endtask
  // two edges cover the bank load and the registered read path
  task automatic rd(input logic [1:0] b, input logic [7:0] a, input logic [7:0] e);
    bwr <= 1'h1;
    bwd <= b;
    bus.addr <= a;
    tick(1);
    bwr <= 1'h0;
    tick(1);
    @(negedge clk_in);
    cmp(rdata, e);
    tick(1);
  endtask
  task automatic flg(input logic [7:0] e);
    @(negedge clk_in);
    cmp({3'h0, bank, vec, mf_f, done_f}, e);
    tick(1);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // watchdog well past the under one hundred cycles the sequence needs
  initial
  begin
    tick(3000);
    fail_count++;
    summarize();
  end
  // main sequence
  initial
  begin
    tick(5);
    rst_n_in <= 1'h1;
    flg(8'h00);
    rd(2'h1, CT, 8'h00);
    wr(2'h1, CT, 8'h01);
    rd(2'h1, CT, 8'h00);
    wr(2'h0, AD, 8'h85);
    wr(2'h0, DT, 8'h3c);
    wr(2'h1, CT, 8'h04);
    rd(2'h1, CT, 8'h00);
    flg(8'h08);
    ien <= 4'h6;
    wr(2'h1, CT, 8'h08);
    wr(2'h1, CT, 8'h0c);
    wr(2'h0, DT, 8'hff);
    ien <= 4'he;
    rd(2'h1, CT, 8'h0c);
    tick(10);
    rd(2'h1, CT, 8'h08);
    flg(8'h0f);
    svc <= 1'h1;
    tick(1);
    svc <= 1'h0;
    flg(8'h09);
    dclr <= 1'h1;
    tick(1);
    dclr <= 1'h0;
    flg(8'h08);
    rd(2'h0, DT, 8'h3c);
    rd(2'h0, AD, 8'h85);
    wr(2'h0, DT, 8'h00);
    wr(2'h1, CT, 8'h02);
    wr(2'h1, CT, 8'h03);
    tick(5);
    rd(2'h1, CT, 8'h02);
    rd(2'h0, DT, 8'h3c);
    summarize();
  end
endmodule
